// *** ira_asserts.sv ***
/*
  Checker for the two-wire link: clock phase lengths, who may drive which line
  and when, and how long the device may stretch the clock.
  Assumes the lines read high when no end pulls them low.
*/
`timescale 1ns/100ps
module ira_asserts #(
  parameter int STRETCH_MAX = 200
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic h_scl_o,
  input wire logic h_scl_oe,
  input wire logic h_sda_o,
  input wire logic h_sda_oe,
  input wire logic d_scl_o,
  input wire logic d_scl_oe,
  input wire logic d_sda_o,
  input wire logic d_sda_oe,
  input wire logic scl,
  input wire logic sda
);
  logic scl_q;
  logic sda_q;
  logic [3:0] bit_cnt;
  int stretch_cnt;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl;
      sda_q <= sda;
    end
  end
  // The count saturates, so a long data phase is never taken for an address byte.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      bit_cnt <= 4'hF;
    end else if (scl && scl_q && sda_q && !sda) begin
      bit_cnt <= 4'h0;
    end else if (scl && !scl_q && bit_cnt != 4'hF) begin
      bit_cnt <= bit_cnt + 4'h1;
    end
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      stretch_cnt <= 0;
    end else begin
      stretch_cnt <= d_scl_oe ? stretch_cnt + 1 : 0;
    end
  end
  default clocking dc @(posedge clk);
  endclocking
  default disable iff (rst);
  sequence s_start;
    scl && $past(scl) && $fell(sda);
  endsequence
  sequence s_grab;
    $rose(d_scl_oe);
  endsequence
  property p_idle;
    $fell(rst) |-> scl && sda && !h_scl_oe && !h_sda_oe && !d_scl_oe && !d_sda_oe;
  endproperty
  property p_drive_low;
    h_scl_oe || h_sda_oe || d_scl_oe || d_sda_oe |-> !h_scl_o && !h_sda_o && !d_scl_o && !d_sda_o;
  endproperty
  property p_stretch_low;
    s_grab |-> $past(h_scl_oe);
  endproperty
  property p_stretch_bound;
    d_scl_oe |-> stretch_cnt <= STRETCH_MAX;
  endproperty
  property p_dev_quiet_high;
    scl && $past(scl) |-> $stable(d_sda_oe);
  endproperty
  property p_start_host;
    s_start |-> h_sda_oe;
  endproperty
  property p_addr_quiet;
    bit_cnt < 4'h8 |-> !d_sda_oe;
  endproperty
  property p_low_min;
    $fell(scl) |-> !scl [*8];
  endproperty
  property p_high_min;
    $rose(scl) |-> scl [*8];
  endproperty
  a_idle: assert property (p_idle) else $error("lines not idle after reset");
  a_drive_low: assert property (p_drive_low) else $error("line driven high");
  a_stretch_low: assert property (p_stretch_low) else $error("stretch began in high phase");
  a_stretch_bound: assert property (p_stretch_bound) else $error("stretch too long");
  a_dev_quiet_high: assert property (p_dev_quiet_high) else $error("device data moved in high phase");
  a_start_host: assert property (p_start_host) else $error("start not made by host");
  a_addr_quiet: assert property (p_addr_quiet) else $error("device drove data in address byte");
  a_low_min: assert property (p_low_min) else $error("clock low phase too short");
  a_high_min: assert property (p_high_min) else $error("clock high phase too short");
endmodule : ira_asserts

// *** ira_dev.sv ***
/*
  Device end: two-wire slave giving a host access to a 16-bit register space,
  with block writes, block reads, command transfers and clock stretching.
  Assumes bus lines synchronous to clk and a user side that answers fetches.
*/
// Notes on behaviour
// R1: Write frame: address, two address bytes, length, data.
// R2: Data bytes go to ascending register addresses.
// R3: Host length byte is one to sixty-four.
// R4: Block read is address write, then repeated start.
// R5: After repeated start, host sends read address.
// R6: Read returns start address first, then ascending.
// R7: Hold clock low until read byte is fetched.
// R8: Command: opcode, count zero to sixty-four, parameters.
// R9: Register address 0x8000 is the command entry.
// R10: Result status updated after every bus access.
// R11: Configuration writes only while engine stopped.
// R12: Each accepted configuration byte stored at once.
// R13: New configuration acts only after engine restart.
// R14: Monitoring registers readable in every engine state.
// R15: Voltage reads return live measurement, not copies.
// R16: Commands invalid for engine state are silently dropped.
// R17: Monitoring area gives signed millivolts per channel.
// R18: Single one or two byte accesses supported.
// R19: Seven-bit addressing at 100 and 400 kbps.
// R20: Storage location is base plus register address.
// R21: Bad length or refused write records error.
`timescale 1ns/100ps
module ira_dev (
  input wire logic clk,
  input wire logic rst,
  ira_if.dev bus,
  input wire ira_pkg::ira_eng_t eng_state,
  input wire logic [31:0] nv_base,
  output logic nv_we,
  output logic [31:0] nv_addr,
  output logic [7:0] nv_wdata,
  output logic fetch_req,
  output logic [15:0] fetch_addr,
  input wire logic fetch_ack,
  input wire logic [7:0] fetch_data,
  output logic cmd_go,
  output logic [7:0] cmd_op,
  output logic par_valid,
  output logic [7:0] par_data,
  output logic [7:0] status
);
  typedef enum {D_IDLE, D_RX, D_AW, D_AK, D_FETCH, D_TX, D_TW, D_TM} ira_dst_t;
  ira_dst_t st;
  logic scl_q;
  logic sda_q;
  logic rise;
  logic fall;
  logic start_c;
  logic stop_c;
  logic [2:0] bits;
  logic [2:0] byte_n;
  logic [7:0] sh;
  logic [7:0] v;
  logic [15:0] addr;
  logic [7:0] rem;
  logic [7:0] res_cur;
  logic mine;
  logic rd_dir;
  logic ack;
  logic sda_low;
  logic have;
  logic sent;
  logic is_cmd;
  logic cfg_ok;
  logic addr_hit;

  function automatic logic cmd_allowed(input logic [7:0] op, input ira_pkg::ira_eng_t e);
    cmd_allowed = !((op == ira_pkg::OP_STOP && e != ira_pkg::IRA_ENG_RUNNING) ||
                    (op == ira_pkg::OP_START && e != ira_pkg::IRA_ENG_STOPPED));
  endfunction : cmd_allowed

  // Lines are sampled once so that edges and bus conditions come from one view.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= bus.scl;
      sda_q <= bus.sda;
    end
  end

  assign rise = bus.scl && !scl_q;
  assign fall = !bus.scl && scl_q;
  assign start_c = bus.scl && scl_q && sda_q && !bus.sda;
  assign stop_c = bus.scl && scl_q && !sda_q && bus.sda;
  assign v = {sh[6:0], bus.sda};
  assign is_cmd = (addr == ira_pkg::CMD_ADDR); // [R9]
  assign cfg_ok = (addr <= ira_pkg::CFG_LAST) && (eng_state == ira_pkg::IRA_ENG_STOPPED); // [R11]
  assign addr_hit = (v[7:1] == ira_pkg::SLAVE_ADDR); // [R19]
  assign fetch_addr = addr; // [R17]

  assign bus.d_scl_o = 1'b0;
  assign bus.d_sda_o = 1'b0;
  // Stretching starts only once the host has pulled the clock low itself.
  assign bus.d_scl_oe = (st == D_FETCH) && !scl_q; // [R7]
  assign bus.d_sda_oe = sda_low;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st <= D_IDLE;
      bits <= 3'h0;
      byte_n <= 3'h0;
      sh <= 8'h00;
      addr <= 16'h0000;
      rem <= 8'h00;
      res_cur <= ira_pkg::RES_OK;
      mine <= 1'b0;
      rd_dir <= 1'b0;
      ack <= 1'b0;
      sda_low <= 1'b0;
      have <= 1'b0;
      sent <= 1'b0;
      status <= ira_pkg::RES_OK;
      cmd_op <= 8'h00;
      nv_we <= 1'b0;
      nv_addr <= 32'h0000_0000;
      nv_wdata <= 8'h00;
      fetch_req <= 1'b0;
      cmd_go <= 1'b0;
      par_valid <= 1'b0;
      par_data <= 8'h00;
    end else begin
      nv_we <= 1'b0;
      fetch_req <= 1'b0;
      cmd_go <= 1'b0;
      par_valid <= 1'b0;
      if (stop_c) begin
        st <= D_IDLE;
        sda_low <= 1'b0;
        mine <= 1'b0;
        if (mine) begin
          status <= res_cur; // [R10]
        end
      end else if (start_c) begin
        // A repeated start keeps address, length and result of the access.
        st <= D_RX;
        bits <= 3'h0;
        byte_n <= 3'h0;
        sda_low <= 1'b0;
        if (!mine) begin
          rem <= 8'h00;
          res_cur <= ira_pkg::RES_OK;
        end
      end else begin
        unique case (st)
          D_IDLE: begin
          end
          D_RX: if (rise) begin
            sh <= v;
            bits <= bits + 3'h1;
            if (bits == 3'h7) begin
              st <= D_AW;
              ack <= 1'b1;
              if (byte_n != 3'h5) begin
                byte_n <= byte_n + 3'h1;
              end
              if (byte_n == 3'h0) begin
                mine <= mine || addr_hit;
                rd_dir <= v[0];
                ack <= addr_hit && !(v[0] && rem == 8'h00); // [R5] [R19] [R21]
              end else if (byte_n == 3'h1) begin
                addr[15:8] <= v; // [R1]
              end else if (byte_n == 3'h2) begin
                addr[7:0] <= v; // [R1]
              end else if (byte_n == 3'h3 && is_cmd) begin
                cmd_op <= v; // [R8]
              end else if (byte_n == 3'h3 || (byte_n == 3'h4 && is_cmd)) begin
                // Lengths of one or two give the single-register accesses.
                if (v > ira_pkg::LEN_MAX || (v == 8'h00 && !is_cmd)) begin // [R3] [R18]
                  ack <= 1'b0;
                  rem <= 8'h00;
                  res_cur <= ira_pkg::RES_LEN; // [R21]
                end else begin
                  rem <= v;
                  if (is_cmd && v == 8'h00) begin
                    cmd_go <= cmd_allowed(cmd_op, eng_state); // [R8] [R16]
                  end
                end
              end else if (rem == 8'h00) begin
                ack <= 1'b0;
                res_cur <= ira_pkg::RES_OVERRUN;
              end else if (is_cmd) begin
                par_valid <= 1'b1;
                par_data <= v;
                rem <= rem - 8'h01;
                if (rem == 8'h01) begin
                  cmd_go <= cmd_allowed(cmd_op, eng_state); // [R16]
                end
              end else if (cfg_ok) begin
                // Each byte is written through at once; the engine is stopped during these writes
                // and picks up the new values when it is restarted.
                nv_we <= 1'b1; // [R12] [R13]
                nv_addr <= nv_base + {16'h0000, addr}; // [R20]
                nv_wdata <= v;
                addr <= addr + 16'h0001; // [R2]
                rem <= rem - 8'h01;
              end else begin
                ack <= 1'b0; // [R11]
                res_cur <= ira_pkg::RES_REFUSED; // [R21]
              end
            end
          end
          D_AW: if (fall) begin
            sda_low <= ack;
            st <= ack ? D_AK : D_IDLE;
          end
          D_AK: if (fall) begin
            sda_low <= 1'b0;
            bits <= 3'h0;
            have <= 1'b0;
            sent <= 1'b0;
            st <= (rd_dir && byte_n == 3'h1) ? D_FETCH : D_RX; // [R4]
          end
          D_FETCH: begin
            if (!have && !sent) begin
              sent <= 1'b1;
              if (addr == ira_pkg::STATUS_ADDR) begin
                sh <= status;
                have <= 1'b1;
              end else begin
                // Every fetch except the status register goes to the user side, so monitoring values are
                // taken live and in any engine state.
                fetch_req <= 1'b1; // [R14] [R15]
              end
            end else if (!have && fetch_ack) begin
              sh <= fetch_data;
              have <= 1'b1;
            end else if (have && !bus.scl) begin
              sda_low <= !sh[7];
              sh <= {sh[6:0], 1'b0};
              bits <= 3'h0;
              st <= D_TX; // [R7]
            end
          end
          D_TX: if (fall) begin
            sda_low <= !sh[7];
            sh <= {sh[6:0], 1'b0};
          end else if (rise) begin
            bits <= bits + 3'h1;
            if (bits == 3'h7) begin
              st <= D_TW;
            end
          end
          D_TW: if (fall) begin
            sda_low <= 1'b0;
            st <= D_TM;
          end
          D_TM: if (rise) begin
            if (!bus.sda && rem > 8'h01) begin
              rem <= rem - 8'h01;
              addr <= addr + 16'h0001; // [R6]
              have <= 1'b0;
              sent <= 1'b0;
              st <= D_FETCH;
            end else begin
              st <= D_IDLE;
            end
          end
        endcase
      end
    end
  end
endmodule : ira_dev

// *** ira_host.sv ***
/*
  Host end: two-wire master that runs whole write, read and command frames
  from a small register port and a 64-byte data buffer.
  Assumes software loads the buffer before a write or command and starts one
  frame at a time.
*/
`timescale 1ns/100ps
module ira_host (
  input wire logic clk,
  input wire logic rst,
  ira_if.host bus,
  input wire logic [2:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata
);
  typedef enum {H_IDLE, H_START, H_BITS, H_STOP} ira_hst_t;
  ira_hst_t st;
  ira_pkg::ira_kind_t kind;
  ira_pkg::ira_kind_t wkind;
  logic fast;
  logic [15:0] addr;
  logic [7:0] len;
  logic [7:0] op;
  logic [7:0] mem [0:63];
  logic [6:0] wp;
  logic [6:0] rp;
  logic [9:0] cnt;
  logic tick;
  logic [1:0] q;
  logic [3:0] bitn;
  logic [6:0] step;
  logic [6:0] last;
  logic [7:0] sh;
  logic [7:0] next_byte;
  logic busy;
  logic nack_err;
  logic len_err;
  logic sda_low;
  logic scl_low;
  logic rx;
  logic stall;
  logic go;
  logic ctrl_wr;
  logic len_ok;
  logic adv;
  logic done;

  assign ctrl_wr = reg_wr && reg_addr == ira_pkg::REG_CTRL && !busy;
  assign wkind = ira_pkg::ira_kind_t'(reg_wdata[1:0]);
  assign len_ok = (len <= ira_pkg::LEN_MAX) && (len != 8'h00 || wkind == ira_pkg::IRA_K_CMD); // [R3] [R8]
  assign go = ctrl_wr && wkind != ira_pkg::IRA_K_NONE && len_ok;
  assign last = len[6:0] + ((kind == ira_pkg::IRA_K_WRITE) ? 7'h03 : 7'h04);
  assign rx = kind == ira_pkg::IRA_K_READ && step >= 7'h05;
  // The clock-high quarter waits while the slave stretches the clock.
  assign stall = (q == 2'h2) && !bus.scl; // [R7]
  assign tick = cnt == 10'h000;
  assign adv = tick && !stall && st != H_IDLE;
  assign done = adv && st == H_STOP && q == 2'h3;
  assign bus.h_scl_o = 1'b0;
  assign bus.h_sda_o = 1'b0;
  assign bus.h_scl_oe = scl_low;
  assign bus.h_sda_oe = sda_low;

  // Quarter-bit enable; the rate is latched with each frame.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt <= 10'h000;
    end else if (tick) begin
      cnt <= (fast ? ira_pkg::QTR_FAST : ira_pkg::QTR_STD) - 10'h001; // [R19]
    end else begin
      cnt <= cnt - 10'h001;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      kind <= ira_pkg::IRA_K_NONE;
      fast <= 1'b0;
      addr <= 16'h0000;
      len <= 8'h00;
      op <= 8'h00;
      len_err <= 1'b0;
    end else if (reg_wr && !busy) begin
      if (reg_addr == ira_pkg::REG_ADDR) begin
        addr <= reg_wdata;
      end else if (reg_addr == ira_pkg::REG_LEN) begin
        len <= reg_wdata[7:0];
      end else if (reg_addr == ira_pkg::REG_OP) begin
        op <= reg_wdata[7:0];
      end else if (reg_addr == ira_pkg::REG_CTRL) begin
        kind <= wkind;
        fast <= reg_wdata[ira_pkg::CTRL_FAST_BIT];
        len_err <= wkind != ira_pkg::IRA_K_NONE && !len_ok; // [R3]
      end
    end
  end

  always_comb begin
    unique case (step)
      7'h00: next_byte = {ira_pkg::SLAVE_ADDR, 1'b0}; // [R1]
      7'h01: next_byte = addr[15:8];
      7'h02: next_byte = addr[7:0];
      7'h03: next_byte = (kind == ira_pkg::IRA_K_CMD) ? op : len; // [R8]
      7'h04: next_byte = (kind == ira_pkg::IRA_K_READ) ? {ira_pkg::SLAVE_ADDR, 1'b1} : // [R5]
                         (kind == ira_pkg::IRA_K_CMD) ? len : mem[0];
      default: next_byte = mem[6'(step - ((kind == ira_pkg::IRA_K_CMD) ? 7'h05 : 7'h04))];
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st <= H_IDLE;
      q <= 2'h0;
      bitn <= 4'h0;
      step <= 7'h00;
      sh <= 8'h00;
      busy <= 1'b0;
      nack_err <= 1'b0;
      sda_low <= 1'b0;
      scl_low <= 1'b0;
    end else if (go) begin
      st <= H_START;
      q <= 2'h0;
      step <= 7'h00;
      busy <= 1'b1;
      nack_err <= 1'b0;
    end else if (adv) begin
      q <= q + 2'h1;
      unique case (st)
        H_IDLE: begin
        end
        H_START: begin
          // Releasing data before clock also makes this a valid repeated start.
          sda_low <= (q == 2'h2) || (q == 2'h3);
          scl_low <= (q == 2'h0) ? scl_low : (q == 2'h3);
          if (q == 2'h3) begin
            bitn <= 4'h0;
            st <= H_BITS;
          end
        end
        H_BITS: begin
          unique case (q)
            2'h0: begin
              if (bitn == 4'h0) begin
                sh <= next_byte;
              end
              if (bitn == 4'h8) begin
                sda_low <= rx && step != last;
              end else begin
                sda_low <= !rx && !((bitn == 4'h0) ? next_byte[7] : sh[7]);
              end
            end
            2'h1: scl_low <= 1'b0;
            2'h2: begin
              if (bitn != 4'h8) begin
                sh <= {sh[6:0], bus.sda};
              end else if (!rx && bus.sda) begin
                nack_err <= 1'b1;
              end
            end
            2'h3: begin
              scl_low <= 1'b1;
              bitn <= bitn + 4'h1;
              if (bitn == 4'h8) begin
                bitn <= 4'h0;
                if (nack_err || step == last) begin
                  st <= H_STOP;
                end else begin
                  step <= step + 7'h01;
                  if (kind == ira_pkg::IRA_K_READ && step == 7'h03) begin
                    st <= H_START; // [R4]
                  end
                end
              end
            end
          endcase
        end
        H_STOP: begin
          sda_low <= (q == 2'h0) || (q == 2'h1);
          scl_low <= 1'b0;
          if (q == 2'h3) begin
            st <= H_IDLE;
            busy <= 1'b0;
          end
        end
      endcase
    end
  end

  // The buffer is loaded by software before a frame and filled by a read frame.
  always_ff @(posedge clk) begin
    if (reg_wr && !busy && reg_addr == ira_pkg::REG_DATA && !wp[6]) begin
      mem[wp[5:0]] <= reg_wdata[7:0];
    end else if (adv && st == H_BITS && q == 2'h3 && bitn == 4'h8 && rx) begin
      mem[6'(step - 7'h05)] <= sh;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wp <= 7'h00;
    end else if (reg_wr && !busy && reg_addr == ira_pkg::REG_DATA && !wp[6]) begin
      wp <= wp + 7'h01;
    end else if (done) begin
      wp <= 7'h00;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rp <= 7'h00;
    end else if (go) begin
      rp <= 7'h00;
    end else if (reg_rd && reg_addr == ira_pkg::REG_DATA) begin
      rp <= rp + 7'h01;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      reg_rdata <= 16'h0000;
    end else if (!reg_rd) begin
      reg_rdata <= 16'h0000;
    end else if (reg_addr == ira_pkg::REG_CTRL) begin
      reg_rdata <= {13'h0000, len_err, nack_err, busy};
    end else if (reg_addr == ira_pkg::REG_ADDR) begin
      reg_rdata <= addr;
    end else if (reg_addr == ira_pkg::REG_LEN) begin
      reg_rdata <= {8'h00, len};
    end else if (reg_addr == ira_pkg::REG_OP) begin
      reg_rdata <= {8'h00, op};
    end else if (reg_addr == ira_pkg::REG_DATA) begin
      reg_rdata <= {8'h00, mem[rp[5:0]]};
    end else begin
      reg_rdata <= 16'h0000;
    end
  end
endmodule : ira_host

// *** ira_if.sv ***
/*
  Two-wire bus between the host end and the device end.
  Each end pulls a line low through its enable; the lines read high otherwise.
*/
`timescale 1ns/100ps
interface ira_if;
  logic h_scl_o;
  logic h_scl_oe;
  logic h_sda_o;
  logic h_sda_oe;
  logic d_scl_o;
  logic d_scl_oe;
  logic d_sda_o;
  logic d_sda_oe;
  logic scl;
  logic sda;
  assign scl = !((h_scl_oe && !h_scl_o) || (d_scl_oe && !d_scl_o));
  assign sda = !((h_sda_oe && !h_sda_o) || (d_sda_oe && !d_sda_o));
  modport host (output h_scl_o, h_scl_oe, h_sda_o, h_sda_oe, input scl, sda);
  modport dev (output d_scl_o, d_scl_oe, d_sda_o, d_sda_oe, input scl, sda);
endinterface : ira_if

// *** ira_pkg.sv ***
/*
  Shared constants and types for the I2C register access link: slave address,
  register map points, result codes, command opcodes and bit timing.
  Assumes both ends run from one 200 MHz clock.
*/
package ira_pkg;
  // Bus address of the slave; plain default, change per board.
  localparam logic [6:0] SLAVE_ADDR = 7'h3C;
  localparam logic [15:0] CFG_LAST = 16'h18FF;
  localparam logic [15:0] MON_BASE = 16'h1900;
  localparam logic [15:0] STATUS_ADDR = 16'h1980;
  localparam logic [15:0] CMD_ADDR = 16'h8000;
  localparam logic [7:0] LEN_MAX = 8'h40;
  localparam logic [7:0] RES_OK = 8'h00;
  localparam logic [7:0] RES_LEN = 8'h01;
  localparam logic [7:0] RES_REFUSED = 8'h02;
  localparam logic [7:0] RES_OVERRUN = 8'h03;
  localparam logic [7:0] OP_START = 8'h01;
  localparam logic [7:0] OP_STOP = 8'h02;
  localparam int CLK_KHZ = 200000;
  localparam int RATE_STD_KHZ = 100;
  localparam int RATE_FAST_KHZ = 400;
  localparam logic [9:0] QTR_STD = 10'(CLK_KHZ / (4 * RATE_STD_KHZ));
  localparam logic [9:0] QTR_FAST = 10'(CLK_KHZ / (4 * RATE_FAST_KHZ));
  localparam logic [2:0] REG_CTRL = 3'h0;
  localparam logic [2:0] REG_ADDR = 3'h1;
  localparam logic [2:0] REG_LEN = 3'h2;
  localparam logic [2:0] REG_OP = 3'h3;
  localparam logic [2:0] REG_DATA = 3'h4;
  localparam int CTRL_FAST_BIT = 2;
  typedef enum logic [1:0] {IRA_ENG_STOPPED, IRA_ENG_STARTING, IRA_ENG_RUNNING, IRA_ENG_FAULT} ira_eng_t;
  typedef enum logic [1:0] {IRA_K_NONE, IRA_K_WRITE, IRA_K_READ, IRA_K_CMD} ira_kind_t;
endpackage : ira_pkg

// *** testbench.sv ***
/*
  Self-checking bench: host and device ends joined by one bus, with a model of
  storage, monitoring values and commands on the device's user side.
  Assumes one 200 MHz clock; frames run at 400 kbps to keep the run short.
*/
`timescale 1ns/100ps
module testbench;
  logic clk;
  logic rst;
  ira_pkg::ira_eng_t eng_state;
  logic [31:0] nv_base;
  logic nv_we;
  logic [31:0] nv_addr;
  logic [7:0] nv_wdata;
  logic fetch_req;
  logic [15:0] fetch_addr;
  logic fetch_ack = 1'b0;
  logic [7:0] fetch_data = 8'h00;
  logic cmd_go;
  logic [7:0] cmd_op;
  logic par_valid;
  logic [7:0] par_data;
  logic [7:0] status;
  logic [2:0] reg_addr;
  logic [15:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [15:0] reg_rdata;
  int n_mismatch = 0;
  int cmp_count = 0;
  int cmd_hits = 0;
  int fwait = 0;
  logic [15:0] fa;
  logic [31:0] exp_addr[$];
  logic [7:0] exp_data[$];
  logic [15:0] exp_fetch[$];
  logic [7:0] wbytes[$];
  ira_if bus_if();
  ira_dev u_ira_dev (.clk(clk), .rst(rst), .bus(bus_if), .eng_state(eng_state), .nv_base(nv_base), .nv_we(nv_we),
    .nv_addr(nv_addr), .nv_wdata(nv_wdata), .fetch_req(fetch_req), .fetch_addr(fetch_addr), .fetch_ack(fetch_ack),
    .fetch_data(fetch_data), .cmd_go(cmd_go), .cmd_op(cmd_op), .par_valid(par_valid), .par_data(par_data),
    .status(status));
  ira_host u_ira_host (.clk(clk), .rst(rst), .bus(bus_if), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
  ira_asserts chk_bus (.clk(clk), .rst(rst), .h_scl_o(bus_if.h_scl_o), .h_scl_oe(bus_if.h_scl_oe),
    .h_sda_o(bus_if.h_sda_o), .h_sda_oe(bus_if.h_sda_oe), .d_scl_o(bus_if.d_scl_o), .d_scl_oe(bus_if.d_scl_oe),
    .d_sda_o(bus_if.d_sda_o), .d_sda_oe(bus_if.d_sda_oe), .scl(bus_if.scl), .sda(bus_if.sda));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  function automatic logic [7:0] mon_val(input logic [15:0] a);
    return a[7:0] ^ a[15:8] ^ 8'h5A;
  endfunction : mon_val
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic results;
    $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : results
  task automatic wr(input logic [2:0] a, input logic [15:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    @(posedge clk);
  endtask : wr
  task automatic rd(input logic [2:0] a, output logic [15:0] d);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    d = reg_rdata;
    @(posedge clk);
  endtask : rd
  task automatic frame(input ira_pkg::ira_kind_t kind, input logic [15:0] a, input logic [7:0] op, input int len,
    input logic [2:0] expctl);
    logic [15:0] v;
    int i;
    wr(ira_pkg::REG_ADDR, a);
    wr(ira_pkg::REG_LEN, 16'(len));
    wr(ira_pkg::REG_OP, {8'h00, op});
    foreach (wbytes[i]) begin
      wr(ira_pkg::REG_DATA, {8'h00, wbytes[i]});
    end
    wr(ira_pkg::REG_CTRL, {13'h0000, 1'b1, kind});
    v = 16'h0001;
    for (i = 0; i < 30000 && v[0] !== 1'b0; i++) begin
      rd(ira_pkg::REG_CTRL, v);
    end
    if (v[0] !== 1'b0) begin
      n_mismatch++;
      $display("unexpected at %0t: frame never ended", $time);
      results();
    end
    chk(32'(v[2:0]), 32'(expctl));
    repeat (20) @(posedge clk);
  endtask : frame
  // User side of the device: storage, delayed fetch answers and command counting.
  always @(posedge clk) begin
    // The answer comes from the address of the pending request, so a read sees the value at fetch time.
    fetch_ack <= (fwait == 1);
    if (fwait == 1) begin
      fetch_data <= mon_val(fa);
    end
    if (fwait > 0) begin
      fwait--;
    end
    if (fetch_req === 1'b1) begin
      fa = fetch_addr;
      fwait = 1 + int'($urandom % 20);
      chk(32'(fetch_addr), (exp_fetch.size() > 0) ? 32'(exp_fetch.pop_front()) : 'x);
    end
    if (nv_we === 1'b1) begin
      chk(nv_addr, (exp_addr.size() > 0) ? exp_addr.pop_front() : 'x);
      chk(32'(nv_wdata), (exp_data.size() > 0) ? 32'(exp_data.pop_front()) : 'x);
    end
    if (cmd_go === 1'b1) begin
      cmd_hits++;
    end
    // No scenario sends a parameter byte, so any pulse here is a fault.
    if (par_valid === 1'b1) begin
      chk(32'(par_data), 'x);
    end
  end
  initial begin
    int i;
    int bad[2];
    logic [15:0] a;
    logic [15:0] rdv;
    logic [31:0] base;
    rst = 1'b1;
    eng_state = ira_pkg::IRA_ENG_STOPPED;
    nv_base = 32'h0000_0000;
    reg_addr = 3'h0;
    reg_wdata = 16'h0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    bad = '{0, 65};
    void'($urandom(32'h664A));
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    // Out of range lengths never reach the wire.
    foreach (bad[i]) begin
      frame(ira_pkg::IRA_K_WRITE, 16'h0000, 8'h00, bad[i], 3'b100);
    end
    chk(32'(status), 32'(ira_pkg::RES_OK));
    base = $urandom & 32'hFFFF_FF80;
    a = 16'($urandom % 32'h1800);
    nv_base <= base;
    wbytes = '{8'($urandom), 8'($urandom)};
    for (i = 0; i < 2; i++) begin
      exp_addr.push_back(base + 32'(a) + 32'(i));
      exp_data.push_back(wbytes[i]);
    end
    frame(ira_pkg::IRA_K_WRITE, a, 8'h00, 2, 3'b000);
    chk(32'(exp_addr.size()), 32'h0000_0000);
    chk(32'(status), 32'(ira_pkg::RES_OK));
    // A configuration write while the engine runs is refused and stores nothing.
    eng_state <= ira_pkg::IRA_ENG_RUNNING;
    wbytes = '{8'h5A};
    frame(ira_pkg::IRA_K_WRITE, a, 8'h00, 1, 3'b010);
    chk(32'(status), 32'(ira_pkg::RES_REFUSED));
    wbytes.delete();
    exp_fetch = '{ira_pkg::MON_BASE, ira_pkg::MON_BASE + 16'h0001};
    frame(ira_pkg::IRA_K_READ, ira_pkg::MON_BASE, 8'h00, 2, 3'b000);
    for (i = 0; i < 2; i++) begin
      rd(ira_pkg::REG_DATA, rdv);
      chk(32'(rdv[7:0]), 32'(mon_val(ira_pkg::MON_BASE + 16'(i))));
    end
    chk(32'(exp_fetch.size()), 32'h0000_0000);
    chk(32'(status), 32'(ira_pkg::RES_OK));
    // A stop request while the engine is stopped must be dropped.
    eng_state <= ira_pkg::IRA_ENG_STOPPED;
    frame(ira_pkg::IRA_K_CMD, ira_pkg::CMD_ADDR, ira_pkg::OP_STOP, 0, 3'b000);
    chk(32'(cmd_hits), 32'h0000_0000);
    chk(32'(cmd_op), 32'(ira_pkg::OP_STOP));
    results();
  end
endmodule : testbench
